// ==== hdl/dsf_status.sv ====
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Status word is 24 bits and read-only; bus writes leave it unchanged.
// - Bits 23 to 12 of the status word always read zero.
// - Bits 11 to 9 give the active channel number, codes 0 to 5.
// - Active-channel field is meaningful only while bit 8 reads one.
// - Bit 8 is set while a transfer is partway done on any channel.
// - Bit 8 is zero when every channel is disabled or idle.
// - Bits 5 to 0 are the done flags, bit n for channel n.
// - Done sets when the last word of a block is written and the channel stops.
// - At block end, enable is cleared or kept as the transfer mode chooses.
// - Last transfer is counter reload, or software clearing the enable.
// - Done with interrupt enable set raises that channel's interrupt request.
// - Software setting a channel's enable clears its done flag.
// - Done clears three cycles after enable is set, else holds old value.
// - In word mode, clearing enable sets done after captured trigger serviced.
// - If enable is kept, the end-of-block interrupt still fires without done.
module dsf_status
    import dsf_pkg::*;
(
    input  wire logic                ref_clk_i,      // Core clock
    input  wire logic                reset_i,        // Sync reset, high
    input  wire dsf_pkg::dsf_bus_t   bus_i,          // Register port request
    output logic [dsf_pkg::STATUS_W-1:0] rdata_o,    // Read data, cycle after read
    input  wire logic [dsf_pkg::NUM_CH-1:0] en_set_i,   // Software sets enable
    input  wire logic [dsf_pkg::NUM_CH-1:0] en_clr_i,   // Software clears enable
    input  wire logic [dsf_pkg::NUM_CH*3-1:0] mode_i,   // Transfer mode per channel
    input  wire logic [dsf_pkg::NUM_CH-1:0] irq_en_i,   // Interrupt enable per channel
    input  wire logic [dsf_pkg::NUM_CH-1:0] reload_i,   // Counter reload on last word
    input  wire logic [dsf_pkg::NUM_CH-1:0] trig_pend_i, // Captured trigger pending
    input  wire logic [dsf_pkg::NUM_CH-1:0] busy_i,     // Channel mid-transfer
    output logic [dsf_pkg::NUM_CH-1:0] en_o,         // Channel enable bits
    output logic [dsf_pkg::NUM_CH-1:0] ch_irq_o,     // Per-channel interrupt request
    output logic                     irq_o           // Masked summary interrupt
);
    import dsf_pkg::*;

    dsf_state_t s;
    dsf_state_t next_s;
    logic [NUM_CH-1:0] blk_end;
    logic [NUM_CH-1:0] done_set;
    logic [NUM_CH-1:0] done_clr;
    logic [NUM_CH-1:0] keep_en;
    logic [NUM_CH-1:0] word_mode;
    logic [STATUS_W-1:0] status_word;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign keep_en[g] = (mode_i[g*MODE_W +: MODE_W] == TM_KEEP_A)
                                || (mode_i[g*MODE_W +: MODE_W] == TM_KEEP_B)
                                || (mode_i[g*MODE_W +: MODE_W] == TM_KEEP_C);
            assign word_mode[g] = (mode_i[g*MODE_W +: MODE_W] == TM_WORD_A)
                                  || (mode_i[g*MODE_W +: MODE_W] == TM_WORD_B);
            assign blk_end[g] = s.en[g] && reload_i[g];
            // Stop by software waits for a pending trigger in word mode
            assign done_set[g] = (blk_end[g] && !keep_en[g])
                                 || (s.stop_pend[g] && !(word_mode[g] && trig_pend_i[g]));
            assign done_clr[g] = s.dly_run[g] && (s.dly[g*2 +: 2] == DELAY_LAST);
        end
    endgenerate

    always_comb begin
        logic              any_busy;
        logic [CH_W-1:0]   cur;
        any_busy = 1'b0;
        cur = CH_RESET;
        next_s = s;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (s.en[i] && busy_i[i]) begin
                any_busy = 1'b1;
                cur = CH_W'(i);
            end
        end
        next_s.act = any_busy;
        if (any_busy) begin
            next_s.ch = cur;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (en_set_i[i] && !s.en[i]) begin
                next_s.en[i] = 1'b1;
                next_s.dly_run[i] = 1'b1;
                next_s.dly[i*2 +: 2] = 2'h0;
                next_s.stop_pend[i] = 1'b0;
            end else if (s.dly_run[i]) begin
                next_s.dly[i*2 +: 2] = s.dly[i*2 +: 2] + 2'h1;
                if (done_clr[i]) begin
                    next_s.dly_run[i] = 1'b0;
                    next_s.done[i] = 1'b0;
                end
            end
            if (en_clr_i[i] && s.en[i]) begin
                next_s.en[i] = 1'b0;
                next_s.stop_pend[i] = 1'b1;
            end
            if (blk_end[i] && !keep_en[i]) begin
                next_s.en[i] = 1'b0;
            end
            if (done_set[i]) begin
                next_s.done[i] = 1'b1;
                next_s.stop_pend[i] = 1'b0;
                next_s.dly_run[i] = 1'b0;
            end
            // Interrupt event: done rising, or block end with enable kept
            if ((done_set[i] || blk_end[i]) && irq_en_i[i]) begin
                next_s.irq_stat[i] = 1'b1;
            end else if (bus_i.wr && bus_i.addr == ADDR_IRQ_STAT && bus_i.wdata[i]) begin
                next_s.irq_stat[i] = 1'b0;
            end
        end
        if (bus_i.wr && bus_i.addr == ADDR_IRQ_MASK) begin
            next_s.irq_mask = bus_i.wdata[NUM_CH-1:0];
        end
        next_s.rdata = '0;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                ADDR_STATUS: next_s.rdata = status_word;
                ADDR_IRQ_STAT: next_s.rdata[NUM_CH-1:0] = s.irq_stat;
                ADDR_IRQ_MASK: next_s.rdata[NUM_CH-1:0] = s.irq_mask;
                default: next_s.rdata = '0;
            endcase
        end
    end

    always_comb begin
        status_word = '0;
        status_word[DONE_LSB +: NUM_CH] = s.done;
        status_word[ACT_BIT] = s.act;
        status_word[CH_LSB +: CH_W] = s.ch;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s <= '0;
            s.done <= DONE_RESET;
            s.ch <= CH_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_o = s.rdata;
    assign en_o = s.en;
    assign ch_irq_o = s.irq_stat & irq_en_i;
    assign irq_o = |(s.irq_stat & s.irq_mask);

    AST_RO_WRITE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (bus_i.wr && bus_i.addr == ADDR_STATUS && !(|done_set) && !(|done_clr)) |=> $stable(s.done))
        else $error("Status write altered done flags");
    AST_RSV_ZERO: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $past(bus_i.rd) && $past(bus_i.addr) == ADDR_STATUS |-> rdata_o[STATUS_W-1:RSV_LSB] == '0)
        else $error("Reserved status bits not zero");
    AST_CH_RANGE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        s.act |-> s.ch < CH_W'(NUM_CH))
        else $error("Active channel code out of range");
    AST_ACT_SET: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        |(s.en & busy_i) |=> s.act)
        else $error("Activity flag missed a busy channel");
    AST_ACT_CLR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !(|(s.en & busy_i)) |=> !s.act)
        else $error("Activity flag set while all idle");
    AST_DONE_END: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (s.en[0] && reload_i[0] && !keep_en[0]) |=> s.done[0] && !s.en[0])
        else $error("Block end did not set done and stop");
    AST_KEEP_EN: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (s.en[1] && reload_i[1] && keep_en[1] && !en_clr_i[1]) |=> s.en[1])
        else $error("Enable cleared in keep mode");
    AST_IRQ_DONE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (done_set[2] && irq_en_i[2]) |=> s.irq_stat[2])
        else $error("Done did not raise interrupt");
    AST_CLR_DELAY: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (en_set_i[2] && !s.en[2] && s.done[2] && !en_clr_i[2] && !reload_i[2])
        ##1 (!en_clr_i[2] && !reload_i[2]) [*3] |-> s.done[2] ##1 !s.done[2])
        else $error("Done clear not three cycles after enable");
    AST_WORD_WAIT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (s.stop_pend[2] && word_mode[2] && trig_pend_i[2] && !blk_end[2]) |=> $stable(s.done[2]))
        else $error("Done set before captured trigger serviced");
    AST_KEEP_IRQ: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (blk_end[1] && keep_en[1] && irq_en_i[1]) |=> s.irq_stat[1])
        else $error("Keep mode block end lost interrupt");
    AST_RDATA_IDLE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !$past(bus_i.rd) |-> rdata_o == '0)
        else $error("Read data not zero outside read answer");

    // Per-channel checks on every channel
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ast
            AST_EN_SET: assert property (@(posedge ref_clk_i) disable iff (reset_i)
                (en_set_i[g] && !s.en[g]) |=> s.en[g])
                else $error("Enable set not taken");
            AST_EN_STOP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
                (en_clr_i[g] && s.en[g]) |=> !s.en[g])
                else $error("Enable clear not taken");
            AST_IRQ_EVENT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
                ((done_set[g] || blk_end[g]) && irq_en_i[g]) |=> s.irq_stat[g])
                else $error("Interrupt event lost");
            AST_DONE_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
                (!done_set[g] && !done_clr[g]) |=> $stable(s.done[g]))
                else $error("Done flag changed without cause");
        end
    endgenerate
endmodule
`default_nettype wire

// ==== pkg/dsf_pkg.sv ====
`default_nettype none
package dsf_pkg;
    localparam int NUM_CH = 6;
    localparam int STATUS_W = 24;
    localparam int CH_W = 3;
    // Register offset on the plain register port
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h1;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
    // Field positions of the status word
    localparam int DONE_LSB = 0;
    localparam int ACT_BIT = 8;
    localparam int CH_LSB = 9;
    localparam int RSV_LSB = 12;
    // Transfer mode field width per channel
    localparam int MODE_W = 3;
    // Pipeline delay from enable set to done clear, in core cycles
    localparam int DONE_CLR_DELAY = 3;
    localparam logic [1:0] DELAY_LAST = 2'h2;
    localparam logic [NUM_CH-1:0] DONE_RESET = 6'h3F;
    localparam logic [CH_W-1:0] CH_RESET = 3'h0;
    // Transfer mode codes that keep the enable bit at block end
    localparam logic [2:0] TM_KEEP_A = 3'h3;
    localparam logic [2:0] TM_KEEP_B = 3'h4;
    localparam logic [2:0] TM_KEEP_C = 3'h5;
    // Word transfer mode codes
    localparam logic [2:0] TM_WORD_A = 3'h1;
    localparam logic [2:0] TM_WORD_B = 3'h5;

    typedef struct packed {
        logic [3:0]          addr;
        logic [STATUS_W-1:0] wdata;
        logic                wr;
        logic                rd;
    } dsf_bus_t;

    typedef struct packed {
        logic                  act;
        logic [CH_W-1:0]       ch;
        logic [NUM_CH-1:0]     done;
        logic [NUM_CH-1:0]     en;
        logic [NUM_CH*2-1:0]   dly;
        logic [NUM_CH-1:0]     dly_run;
        logic [NUM_CH-1:0]     stop_pend;
        logic [NUM_CH-1:0]     irq_stat;
        logic [NUM_CH-1:0]     irq_mask;
        logic [STATUS_W-1:0]   rdata;
    } dsf_state_t;
endpackage
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dsf_pkg::*;
    logic                ref_clk_i;
    logic                reset_i;
    dsf_bus_t            bus_i;
    logic [STATUS_W-1:0] rdata_o;
    logic [NUM_CH-1:0]   en_set_i, en_clr_i, irq_en_i, reload_i, trig_pend_i, busy_i, en_o, ch_irq_o;
    logic [NUM_CH*3-1:0] mode_i;
    logic                irq_o, rd_q;
    logic [23:0]         exp_q[$];
    logic [31:0]         seed;
    int                  fails, num_checks;

    dsf_status dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .en_set_i(en_set_i), .en_clr_i(en_clr_i), .mode_i(mode_i), .irq_en_i(irq_en_i),
        .reload_i(reload_i), .trig_pend_i(trig_pend_i), .busy_i(busy_i), .en_o(en_o),
        .ch_irq_o(ch_irq_o), .irq_o(irq_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [23:0] st(input logic [2:0] ch, input logic act, input logic [5:0] dn);
        return {12'h000, ch, act, 2'b00, dn};
    endfunction

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [23:0] d);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        tick(1);
        bus_i <= '0;
        tick(1);
    endtask

    task automatic bus_rd(input logic [3:0] a, input logic [23:0] e);
        bus_i <= '{addr: a, wdata: 24'h000000, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        tick(1);
        bus_i <= '0;
        tick(1);
    endtask

    // Read data checked in the cycle after each read strobe
    always @(posedge ref_clk_i) begin
        if (rd_q === 1'b1) chk(rdata_o, exp_q.pop_front());
        rd_q <= bus_i.rd;
    end

    initial begin
        tick(20000);
        fails++;
        print_verdict();
    end

    initial begin
        logic [5:0] m;
        {bus_i, en_set_i, en_clr_i, irq_en_i, reload_i, trig_pend_i, busy_i, mode_i} = '0;
        reset_i = 1'b1;
        rd_q = 1'b0;
        seed = 32'h0354;
        tick(3);
        reset_i <= 1'b0;
        bus_rd(ADDR_STATUS, 24'h00003F);
        seed = xs(seed);
        bus_wr(ADDR_STATUS, seed[23:0] & 24'hFFFF3F);
        bus_rd(ADDR_STATUS, 24'h00003F);
        bus_rd(4'h7, 24'h000000);
        seed = xs(seed);
        m = seed[5:0];
        bus_wr(ADDR_IRQ_MASK, {18'h0, m});
        bus_rd(ADDR_IRQ_MASK, {18'h0, m});
        bus_wr(ADDR_IRQ_MASK, 24'h00003F);
        mode_i <= {9'h000, TM_WORD_A, TM_KEEP_A, 3'h0};
        irq_en_i <= 6'h3F;
        en_set_i <= 6'h07;
        tick(1);
        en_set_i <= 6'h00;
        bus_rd(ADDR_STATUS, 24'h00003F);
        tick(3);
        bus_rd(ADDR_STATUS, 24'h000038);
        chk({18'h0, en_o}, 24'h000007);
        busy_i <= 6'h0C;
        tick(2);
        bus_rd(ADDR_STATUS, st(3'h2, 1'b1, 6'h38));
        busy_i <= 6'h00;
        tick(2);
        bus_rd(ADDR_STATUS, st(3'h2, 1'b0, 6'h38));
        reload_i <= 6'h01;
        tick(1);
        reload_i <= 6'h00;
        tick(2);
        chk({18'h0, en_o}, 24'h000006);
        bus_rd(ADDR_STATUS, st(3'h2, 1'b0, 6'h39));
        chk({18'h0, ch_irq_o}, 24'h000001);
        chk({23'h0, irq_o}, 24'h000001);
        bus_wr(ADDR_IRQ_STAT, 24'h00003F);
        chk({23'h0, irq_o}, 24'h000000);
        reload_i <= 6'h02;
        tick(1);
        reload_i <= 6'h00;
        tick(2);
        chk({18'h0, en_o}, 24'h000006);
        bus_rd(ADDR_STATUS, st(3'h2, 1'b0, 6'h39));
        chk({18'h0, ch_irq_o}, 24'h000002);
        bus_wr(ADDR_IRQ_STAT, 24'h00003F);
        trig_pend_i <= 6'h04;
        en_clr_i <= 6'h04;
        tick(1);
        en_clr_i <= 6'h00;
        tick(3);
        chk({18'h0, en_o}, 24'h000002);
        bus_rd(ADDR_STATUS, st(3'h2, 1'b0, 6'h39));
        trig_pend_i <= 6'h00;
        tick(3);
        bus_rd(ADDR_STATUS, st(3'h2, 1'b0, 6'h3D));
        bus_wr(ADDR_IRQ_MASK, 24'h000000);
        chk({23'h0, irq_o}, 24'h000000);
        reset_i <= 1'b1;
        tick(3);
        reset_i <= 1'b0;
        bus_rd(ADDR_STATUS, 24'h00003F);
        chk({18'h0, en_o}, 24'h000000);
        tick(2);
        if (exp_q.size() != 0) fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
